// ---- core/dpr_consts.vh ----
// constants for the dual-port block memory
// assumes the includer works in plain verilog-2005
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// ----------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------
`define DPR_ADDR_BITS     14
`define DPR_DATA_BITS     16384
`define DPR_PAR_BITS      2048
`define DPR_MAX_DATA      32
`define DPR_MAX_PAR       4
`define DPR_BYTE_SHIFT    3

// ----------------------------------------------------------------
// write modes
// ----------------------------------------------------------------
`define DPR_WRITE_FIRST   2'h0
`define DPR_READ_FIRST    2'h1
`define DPR_NO_CHANGE     2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPR_INIT_OUT      36'h000000000
`define DPR_SRVAL         36'h000000000
`define DPR_INIT_BYTE     8'h00
`define DPR_INIT_PARITY   1'h0

`endif

// ---- core/dpr_block_ram.v ----
// dual-port block memory: 16384 data bits plus 2048 parity bits
// assumes both ports are driven by fabric logic on clk; no pin inputs
`timescale 1ns/10ps
`include "dpr_consts.vh"

// Summary of operation
// - 18432 bits stored; 16384 reachable when the port carries no parity.
// - two identical ports A and B, each with own data and control lines.
// - both ports reach one common array, so data crosses either way.
// - single-port mode keeps only port A; dual-port sets both widths.
// - port width chosen among 1, 2, 4, 9, 18, 36 for read and write.
// - address bits are 14 minus log2 of data width; depth is 2^that.
// - 9, 18, 36 widths carry 1, 2, 4 parity bits beside 8, 16, 32.
// - widths 4, 2, 1 have no parity; parity is plain stored data.
// - wide reads join consecutive narrow words written by the other port.
// - narrow reads return one slice of a wide word from the other port.
// - each parity bit stays with its own data byte across widths.
// - initial contents, output defaults, widths, write modes configurable.
// - write happens only with port enable and write enable both high.
// - enabled read presents addressed contents on the data outputs.
// - during a write output shows new, old, or unchanged data per mode.
// - enable, write enable and set/reset active high, each invertible.
module dpr_block_ram #(
  parameter       WIDTH_A      = 36,
  parameter       WIDTH_B      = 36,
  parameter       DUAL_PORT    = 1,
  parameter [1:0] WRITE_MODE_A = `DPR_WRITE_FIRST,
  parameter [1:0] WRITE_MODE_B = `DPR_WRITE_FIRST,
  parameter [35:0] INIT_OUT_A  = `DPR_INIT_OUT,
  parameter [35:0] INIT_OUT_B  = `DPR_INIT_OUT,
  parameter [35:0] SRVAL_A     = `DPR_SRVAL,
  parameter [35:0] SRVAL_B     = `DPR_SRVAL,
  parameter [7:0]  INIT_BYTE   = `DPR_INIT_BYTE,
  parameter [0:0]  INIT_PARITY = `DPR_INIT_PARITY,
  parameter [0:0]  INV_EN_A    = 1'h0,
  parameter [0:0]  INV_WE_A    = 1'h0,
  parameter [0:0]  INV_SSR_A   = 1'h0,
  parameter [0:0]  INV_EN_B    = 1'h0,
  parameter [0:0]  INV_WE_B    = 1'h0,
  parameter [0:0]  INV_SSR_B   = 1'h0
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // port a
  input  wire        enableA,
  input  wire        writeEnableA,
  input  wire        syncOutputSetResetA,
  input  wire [13:0] addrA,
  input  wire [31:0] writeDataInA,
  input  wire [3:0]  parityDataInA,
  output reg  [31:0] readDataOutA_q,
  output reg  [3:0]  parityDataOutA_q,
  // port b
  input  wire        enableB,
  input  wire        writeEnableB,
  input  wire        syncOutputSetResetB,
  input  wire [13:0] addrB,
  input  wire [31:0] writeDataInB,
  input  wire [3:0]  parityDataInB,
  output reg  [31:0] readDataOutB_q,
  output reg  [3:0]  parityDataOutB_q
);

  // ----------------------------------------------------------------
  // width derived geometry
  // ----------------------------------------------------------------
  function integer dataWidth;
    input integer w;
    begin
      dataWidth = (w >= 9) ? (w - w / 9) : w;
    end
  endfunction

  function integer log2Of;
    input integer v;
    integer k;
    begin
      log2Of = 0;
      for (k = 0; k < 6; k = k + 1) begin
        if ((1 << k) == v) begin
          log2Of = k;
        end
      end
    end
  endfunction

  localparam integer DWA  = dataWidth(WIDTH_A);
  localparam integer DWB  = dataWidth(WIDTH_B);
  localparam integer PWA  = DWA / 8;
  localparam integer PWB  = DWB / 8;
  localparam integer LOGA = log2Of(DWA);
  localparam integer LOGB = log2Of(DWB);

  // ----------------------------------------------------------------
  // control polarity and port presence
  // ----------------------------------------------------------------
  wire enA  = enableA ^ INV_EN_A;
  wire weA  = writeEnableA ^ INV_WE_A;
  wire ssrA = syncOutputSetResetA ^ INV_SSR_A;
  // single-port mode: port b is simply never enabled
  wire enB  = (DUAL_PORT != 0) & (enableB ^ INV_EN_B);
  wire weB  = writeEnableB ^ INV_WE_B;
  wire ssrB = syncOutputSetResetB ^ INV_SSR_B;

  // bit offset into the flat array; shifting out the high address bits
  // leaves exactly 14 - log2(width) usable address bits
  wire [13:0] baseA = addrA << LOGA;
  wire [13:0] baseB = addrB << LOGB;
  // parity bit offset follows the byte index, keeping bit with byte
  wire [10:0] pBaseA = baseA[13:`DPR_BYTE_SHIFT];
  wire [10:0] pBaseB = baseB[13:`DPR_BYTE_SHIFT];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [`DPR_DATA_BITS-1:0] dataMem;
  reg [`DPR_PAR_BITS-1:0]  parMem;
  reg [31:0] rdA;
  reg [3:0]  rdPA;
  reg [31:0] rdB;
  reg [3:0]  rdPB;
  reg [31:0] wrA;
  reg [3:0]  wrPA;
  reg [31:0] wrB;
  reg [3:0]  wrPB;
  integer i;
  // the write loop has its own index so that no variable has two writers
  integer j;

  // both ports see the same flat array, so any width pairing joins or
  // splits words by plain bit position
  always @* begin
    rdA  = 32'h00000000;
    rdPA = 4'h0;
    rdB  = 32'h00000000;
    rdPB = 4'h0;
    wrA  = 32'h00000000;
    wrPA = 4'h0;
    wrB  = 32'h00000000;
    wrPB = 4'h0;
    for (i = 0; i < `DPR_MAX_DATA; i = i + 1) begin
      if (i < DWA) begin
        rdA[i] = dataMem[baseA + i];
        wrA[i] = writeDataInA[i];
      end
      if (i < DWB) begin
        rdB[i] = dataMem[baseB + i];
        wrB[i] = writeDataInB[i];
      end
    end
    for (i = 0; i < `DPR_MAX_PAR; i = i + 1) begin
      if (i < PWA) begin
        rdPA[i] = parMem[pBaseA + i];
        wrPA[i] = parityDataInA[i];
      end
      if (i < PWB) begin
        rdPB[i] = parMem[pBaseB + i];
        wrPB[i] = parityDataInB[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // array writes
  // ----------------------------------------------------------------
  // a same-bit collision goes to the port with the lower bit offset, and to port b when the offsets match; users must
  // not depend on that
  always @(posedge clk) begin
    if (rst) begin
      dataMem <= {(`DPR_DATA_BITS / 8){INIT_BYTE}};
      parMem  <= {`DPR_PAR_BITS{INIT_PARITY}};
    end else begin
      for (j = 0; j < `DPR_MAX_DATA; j = j + 1) begin
        if (enA && weA && j < DWA) begin
          dataMem[baseA + j] <= writeDataInA[j];
        end
        if (enB && weB && j < DWB) begin
          dataMem[baseB + j] <= writeDataInB[j];
        end
      end
      for (j = 0; j < `DPR_MAX_PAR; j = j + 1) begin
        if (enA && weA && j < PWA) begin
          parMem[pBaseA + j] <= parityDataInA[j];
        end
        if (enB && weB && j < PWB) begin
          parMem[pBaseB + j] <= parityDataInB[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      readDataOutA_q   <= INIT_OUT_A[31:0];
      parityDataOutA_q <= INIT_OUT_A[35:32];
    end else if (enA) begin
      if (ssrA) begin
        readDataOutA_q   <= SRVAL_A[31:0];
        parityDataOutA_q <= SRVAL_A[35:32];
      end else if (!weA) begin
        readDataOutA_q   <= rdA;
        parityDataOutA_q <= rdPA;
      end else if (WRITE_MODE_A == `DPR_WRITE_FIRST) begin
        readDataOutA_q   <= wrA;
        parityDataOutA_q <= wrPA;
      end else if (WRITE_MODE_A == `DPR_READ_FIRST) begin
        readDataOutA_q   <= rdA;
        parityDataOutA_q <= rdPA;
      end
    end
  end

  // port b mirrors port a with its own controls and output register
  always @(posedge clk) begin
    if (rst) begin
      readDataOutB_q   <= INIT_OUT_B[31:0];
      parityDataOutB_q <= INIT_OUT_B[35:32];
    end else if (enB) begin
      if (ssrB) begin
        readDataOutB_q   <= SRVAL_B[31:0];
        parityDataOutB_q <= SRVAL_B[35:32];
      end else if (!weB) begin
        readDataOutB_q   <= rdB;
        parityDataOutB_q <= rdPB;
      end else if (WRITE_MODE_B == `DPR_WRITE_FIRST) begin
        readDataOutB_q   <= wrB;
        parityDataOutB_q <= wrPB;
      end else if (WRITE_MODE_B == `DPR_READ_FIRST) begin
        readDataOutB_q   <= rdB;
        parityDataOutB_q <= rdPB;
      end
    end
  end

endmodule

// ---- verification/dpr_block_ram_asserts.sv ----
// assertions on the memory ports: a is 36 wide, b is 9 wide read-first
// assumes a bind onto every port of the memory, one clock
`timescale 1ns/10ps
module dpr_block_ram_asserts #(
  parameter [35:0] SRV = 36'h0
) (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // port a
  input wire        enableA,
  input wire        writeEnableA,
  input wire        syncOutputSetResetA,
  input wire [13:0] addrA,
  input wire [31:0] writeDataInA,
  input wire [3:0]  parityDataInA,
  input wire [31:0] readDataOutA_q,
  input wire [3:0]  parityDataOutA_q,
  // port b
  input wire        enableB,
  input wire        writeEnableB,
  input wire        syncOutputSetResetB,
  input wire [13:0] addrB,
  input wire [31:0] writeDataInB,
  input wire [3:0]  parityDataInB,
  input wire [31:0] readDataOutB_q,
  input wire [3:0]  parityDataOutB_q
);
  // ------------------------------------------------------------
  // port rules
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [35:0] outA = {parityDataOutA_q, readDataOutA_q};
  wire [35:0] outB = {parityDataOutB_q, readDataOutB_q};
  wire        wrA  = enableA && writeEnableA && !syncOutputSetResetA;
  wire        rdA  = enableA && !writeEnableA && !syncOutputSetResetA;
  AST_HOLD_A: assert property (!enableA |=> $stable(outA))
    else $error("port a output moved while idle");
  AST_HOLD_B: assert property (!enableB |=> $stable(outB))
    else $error("port b output moved while idle");
  AST_RST: assert property ($fell(rst) |-> outA == 0 && outB == 0)
    else $error("outputs not at initial value after reset");
  AST_WF_A: assert property (wrA |=> outA == $past({parityDataInA,
    writeDataInA})) else $error("port a write did not show new data");
  // b must stay quiet so that no collision muddies the stored word
  AST_RAW_A: assert property (wrA && !enableB ##1 rdA && !enableB &&
    addrA[8:0] == $past(addrA[8:0]) |=> outA ==
    $past({parityDataInA, writeDataInA}, 2))
    else $error("port a read back differs from write");
  AST_SSR_A: assert property (enableA && syncOutputSetResetA |=>
    outA == SRV) else $error("port a set value wrong");
  AST_SSR_B: assert property (enableB && syncOutputSetResetB |=>
    outB == 36'h0) else $error("port b set value wrong");
  AST_NO_PAR_B: assert property (outB[35:33] == 0 && outB[31:8] == 0)
    else $error("port b unused output bits set");
  cover property (wrA ##1 rdA);
  cover property (enableB && !writeEnableB);
  cover property (enableA && syncOutputSetResetA);
endmodule

// ---- verification/dpr_fabric_side.sv ----
// fabric-side model that drives port b of the memory
// assumes the bench calls acc_b and reads port b outputs itself
`timescale 1ns/10ps
module dpr_fabric_side (
  input  wire        clk,
  output reg         enableB = 1'b0,
  output reg         writeEnableB = 1'b0,
  output reg         syncOutputSetResetB = 1'b0,
  output reg  [13:0] addrB = 14'h0,
  output reg  [31:0] writeDataInB = 32'h0,
  output reg  [3:0]  parityDataInB = 4'h0
);
  // takes no account of which word port a is using in that cycle
  task acc_b(input en, we, sync_output_set_reset, input [13:0] a, input [8:0] d);
    begin
      @(negedge clk);
      enableB = en;
      writeEnableB = we;
      syncOutputSetResetB = sync_output_set_reset;
      addrB = a;
      // upper lanes are unused at width 9; junk shows they are ignored
      writeDataInB = {24'ha5a5a5, d[7:0]};
      parityDataInB = {3'h5, d[8]};
      @(posedge clk);
      // drop the request at the next falling edge, never just after the
      // sampling edge; the caller checks the outputs from there on
      @(negedge clk);
      enableB = 1'b0;
      writeDataInB = ~writeDataInB;
    end
  endtask
endmodule

// ---- verification/dpr_block_ram_bench.sv ----
// bench: port a 36 wide write-first, port b 9 wide read-first
// assumes one 25 MHz clock shared by both ports
`timescale 1ns/10ps
module dpr_block_ram_bench;
  // ------------------------------------------------------------
  // clock, stimulus and design
  // ------------------------------------------------------------
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         enA = 1'b0, weA = 1'b0, ssrA = 1'b0;
  reg  [13:0] adA = 14'h0;
  reg  [35:0] dA  = 36'h0;
  wire        enB, weB, ssrB;
  wire [13:0] adB;
  wire [31:0] dB, qA, qB;
  wire [3:0]  pB, pqA, pqB;
  wire [35:0] ra = {pqA, qA};
  wire [35:0] rb = {pqB, qB};
  integer     nFail = 0;
  integer     testsRun = 0;
  integer     k;
  always #20 clk = ~clk;
  dpr_fabric_side i_far (.clk(clk), .enableB(enB), .writeEnableB(weB),
    .syncOutputSetResetB(ssrB), .addrB(adB), .writeDataInB(dB),
    .parityDataInB(pB));
  dpr_block_ram #(.WIDTH_B(9), .WRITE_MODE_B(2'h1), .SRVAL_A(36'h987654321))
    i_dut (.clk(clk), .rst(rst), .enableA(enA), .writeEnableA(weA),
    .syncOutputSetResetA(ssrA), .addrA(adA), .writeDataInA(dA[31:0]),
    .parityDataInA(dA[35:32]), .readDataOutA_q(qA), .parityDataOutA_q(pqA),
    .enableB(enB), .writeEnableB(weB), .syncOutputSetResetB(ssrB),
    .addrB(adB), .writeDataInB(dB), .parityDataInB(pB),
    .readDataOutB_q(qB), .parityDataOutB_q(pqB));
  // ------------------------------------------------------------
  // access tasks and checks
  // ------------------------------------------------------------
  task chk(input [35:0] got, input [35:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        nFail = nFail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc_a(input en, we, sync_output_set_reset, input [13:0] a, input [35:0] d);
    begin
      @(negedge clk);
      {enA, weA, ssrA, adA, dA} = {en, we, sync_output_set_reset, a, d};
      @(posedge clk);
      #1;
    end
  endtask
  task closeOut;
    begin
      $display("fails=%0d checks=%0d", nFail, testsRun);
      if (nFail == 0 && testsRun > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // watchdog and scenario
  // ------------------------------------------------------------
  // the scenario needs well under 100 cycles; 500 leaves ample margin
  initial begin
    #20000;
    nFail = nFail + 1;
    closeOut;
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk(ra, 36'h0);
    acc_a(1, 0, 0, 5, 0);
    chk(ra, 36'h0);
    acc_a(1, 1, 0, 3, 36'ha44332211);
    chk(ra, 36'ha44332211);
    acc_a(1, 0, 0, 3, 0);
    chk(ra, 36'ha44332211);
    // byte k of the wide word, with parity bit k of 4'ha beside it
    for (k = 0; k < 4; k = k + 1) begin
      i_far.acc_b(1, 0, 0, 14'h00c + k[13:0], 9'h000);
      chk(rb, {3'h0, k[0], 24'h0, 8'h11 * (k[7:0] + 8'h01)});
    end
    for (k = 0; k < 4; k = k + 1) begin
      i_far.acc_b(1, 1, 0, 14'h028 + k[13:0], {k[0], 8'h50 + k[7:0]});
      chk(rb, 36'h0);
    end
    acc_a(1, 0, 0, 10, 0);
    chk(ra, 36'ha53525150);
    acc_a(0, 1, 0, 3, 36'h5deadbeef);
    chk(ra, 36'ha53525150);
    acc_a(1, 0, 0, 3, 0);
    chk(ra, 36'ha44332211);
    acc_a(1, 0, 1, 3, 0);
    chk(ra, 36'h987654321);
    acc_a(1, 0, 0, 3, 0);
    chk(ra, 36'ha44332211);
    // a non-zero read first, so that the set value below is visible
    i_far.acc_b(1, 0, 0, 14'h00d, 9'h000);
    chk(rb, 36'h100000022);
    i_far.acc_b(1, 0, 1, 14'h00c, 9'h000);
    chk(rb, 36'h0);
    acc_a(0, 0, 0, 0, 0);
    closeOut;
  end
endmodule
bind dpr_block_ram dpr_block_ram_asserts #(.SRV(SRVAL_A)) u_chk (
  .clk(clk), .rst(rst),
  .enableA(enableA), .writeEnableA(writeEnableA),
  .syncOutputSetResetA(syncOutputSetResetA), .addrA(addrA),
  .writeDataInA(writeDataInA), .parityDataInA(parityDataInA),
  .readDataOutA_q(readDataOutA_q), .parityDataOutA_q(parityDataOutA_q),
  .enableB(enableB), .writeEnableB(writeEnableB),
  .syncOutputSetResetB(syncOutputSetResetB), .addrB(addrB),
  .writeDataInB(writeDataInB), .parityDataInB(parityDataInB),
  .readDataOutB_q(readDataOutB_q), .parityDataOutB_q(parityDataOutB_q));
